// ### hdl/idc_checker.sv
// Validity check of a clock generator idle request
`timescale 1ns/1ps
`default_nettype none
module idc_checker
  import idc_pkg::*;
(
  input  wire logic [15:0] cfg,
  output logic             bad
);

  function automatic logic clk_bad(input logic [15:0] c);
    return c[IDC_CLK_BIT] &&
           ((c & IDC_CLK_REQ) != IDC_CLK_REQ);
  endfunction

  assign bad = clk_bad(cfg);

endmodule
`default_nettype wire

// ### hdl/idc_pkg.sv
// Package: register map, field positions and types of the idle domain control
package idc_pkg;

  localparam int unsigned IDC_ADDR_W = 4;
  localparam logic [IDC_ADDR_W-1:0] IDC_CFG_OFS  = 4'h0;
  localparam logic [IDC_ADDR_W-1:0] IDC_STAT_OFS = 4'h4;
  localparam logic [IDC_ADDR_W-1:0] IDC_CMD_OFS  = 4'h8;

  localparam int unsigned IDC_CPU_BIT    = 0;
  localparam int unsigned IDC_MPER_BIT   = 1;
  localparam int unsigned IDC_ICACHE_BIT = 2;
  localparam int unsigned IDC_PER_BIT    = 3;
  localparam int unsigned IDC_CLK_BIT    = 4;
  localparam int unsigned IDC_EMI_BIT    = 5;
  localparam int unsigned IDC_IOP_BIT    = 6;
  localparam int unsigned IDC_MEMP_BIT   = 7;
  localparam int unsigned IDC_INSP_BIT   = 8;
  localparam int unsigned IDC_CLKE_BIT   = 9;

  localparam logic [15:0] IDC_CFG_RST  = 16'h0000;
  localparam logic [15:0] IDC_CFG_MASK = 16'h03FF;
  // Bits that must accompany a clock generator idle
  localparam logic [15:0] IDC_CLK_REQ  = 16'h03E7;

  // Status bits of the command/status word
  localparam int unsigned IDC_ST_ERR_BIT  = 0;
  localparam int unsigned IDC_ST_IDLE_BIT = 1;

  typedef struct packed {
    logic clk_ext;
    logic instr_port;
    logic memory_port;
    logic io_port;
    logic ext_mem_if;
    logic clock_gen;
    logic periph;
    logic instr_cache;
    logic master_periph;
    logic cpu;
  } idc_dom_t;

  typedef enum logic [2:0] {
    IDC_RUN  = 3'b001,
    IDC_IDLE = 3'b010,
    IDC_ERR  = 3'b100
  } idc_state_t;

endpackage

// ### hdl/idc_wb_slave.sv
// Classic Wishbone slave front end with single-cycle ack
`timescale 1ns/1ps
`default_nettype none
module idc_wb_slave
  import idc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [IDC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  output logic                       wb_ack_o,
  output logic                       wr_stb,
  output logic                       rd_stb,
  output logic [IDC_ADDR_W-1:0]      acc_adr,
  output logic [3:0]                 acc_sel
);

  logic ack_q;

  // Ack one cycle after request; drop right after so no double access
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wr_stb   = ack_q && wb_cyc_i && wb_stb_i && wb_we_i;
  assign rd_stb   = ack_q && wb_cyc_i && wb_stb_i && !wb_we_i;
  assign acc_adr  = wb_adr_i;
  assign acc_sel  = wb_sel_i;

endmodule
`default_nettype wire

// ### hdl/idle_domain_control.sv
// Idle domain control: config register, IDLE capture and domain disables
// Summary of operation
// - With the memory-side port bit set, IDLE disables the DMA/host port.
// - Bit 6 at reset 0 keeps the I/O port running, set disables it on IDLE.
// - Bit 5 at reset 0 keeps the memory interface, set disables it on IDLE.
// - Bit 4 resets to 0; with it and bit 9 clear the clock generator runs.
// - Bits 4 and 9 both set, with all needed domain bits, make IDLE stop the clock generator and clock.
// - Bit 4 set without bit 9 makes IDLE raise a bus error interrupt.
// - Clock idle with any needed domain bit clear raises a bus error.
// - Bit 9 is the read/write extended clock idle bit, reset 0.
// - Bit 8 idles the instruction port on IDLE when set.
// - Bit 7 is the memory-side port bit; clear keeps the port active.
// - Bits 2, 1, 0 idle instruction cache, master peripherals and CPU.
`timescale 1ns/1ps
`default_nettype none
module idle_domain_control
  import idc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [IDC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  idle_exec,
  input  wire logic                  wake,
  output idc_dom_t                   dom_disable,
  output logic                       sysclk_stop,
  output logic                       bus_err_irq
);

  ////////////////////////////////////////////////////////////////////
  logic                  wr_stb;
  logic [IDC_ADDR_W-1:0] acc_adr;
  logic [3:0]            acc_sel;
  logic [15:0]           cfg_q;
  logic [15:0]           cap_q;
  logic                  bad;
  logic                  err_q;
  logic [31:0]           dat_q;
  idc_state_t            state_q;

  idc_wb_slave u_wb (
    .clk      (clk),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wr_stb   (wr_stb),
    .rd_stb   (),
    .acc_adr  (acc_adr),
    .acc_sel  (acc_sel)
  );

  idc_checker u_chk (
    .cfg (cfg_q),
    .bad (bad)
  );

  ////////////////////////////////////////////////////////////////////
  // Configuration register, bits 15..10 read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= IDC_CFG_RST;
    end else if (wr_stb && acc_adr == IDC_CFG_OFS) begin
      if (acc_sel[0]) begin
        cfg_q[7:0] <= wb_dat_i[7:0] & IDC_CFG_MASK[7:0];
      end
      if (acc_sel[1]) begin
        cfg_q[15:8] <= wb_dat_i[15:8] & IDC_CFG_MASK[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // IDLE sequencing; invalid clock setups refuse the idle entirely
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= IDC_RUN;
      cap_q   <= 16'h0000;
    end else begin
      case (state_q)
        IDC_RUN: begin
          if (idle_exec) begin
            if (bad) begin
              state_q <= IDC_ERR;
            end else begin
              cap_q   <= cfg_q;
              state_q <= IDC_IDLE;
            end
          end
        end
        IDC_IDLE: begin
          // Later config writes wait for the next IDLE
          if (wake) begin
            state_q <= IDC_RUN;
            cap_q   <= 16'h0000;
          end
        end
        IDC_ERR: begin
          state_q <= IDC_RUN;
        end
        default: begin
          state_q <= IDC_RUN;
        end
      endcase
    end
  end

  // Sticky error flag; a new error wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (state_q == IDC_ERR) begin
      err_q <= 1'b1;
    end else if (wr_stb && acc_adr == IDC_CMD_OFS && acc_sel[0] &&
                 wb_dat_i[IDC_ST_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  assign bus_err_irq = err_q;

  ////////////////////////////////////////////////////////////////////
  // Domain disables from the captured copy
  always_comb begin
    dom_disable               = '0;
    dom_disable.cpu           = cap_q[IDC_CPU_BIT];
    dom_disable.master_periph = cap_q[IDC_MPER_BIT];
    dom_disable.instr_cache   = cap_q[IDC_ICACHE_BIT];
    dom_disable.periph        = cap_q[IDC_PER_BIT];
    dom_disable.clock_gen     = cap_q[IDC_CLK_BIT] &&
                                cap_q[IDC_CLKE_BIT];
    dom_disable.ext_mem_if    = cap_q[IDC_EMI_BIT];
    dom_disable.io_port       = cap_q[IDC_IOP_BIT];
    dom_disable.memory_port   = cap_q[IDC_MEMP_BIT];
    dom_disable.instr_port    = cap_q[IDC_INSP_BIT];
    dom_disable.clk_ext       = cap_q[IDC_CLKE_BIT];
  end

  assign sysclk_stop = dom_disable.clock_gen;

  ////////////////////////////////////////////////////////////////////
  // Read data registered from the request in the cycle before ack
  always_ff @(posedge clk) begin
    if (rst) begin
      dat_q <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      case (wb_adr_i)
        IDC_CFG_OFS:  dat_q <= {16'h0000, cfg_q};
        IDC_STAT_OFS: dat_q <= {16'h0000, cap_q};
        IDC_CMD_OFS:  dat_q <= {30'h00000000,
                                state_q == IDC_IDLE, err_q};
        default:      dat_q <= 32'h00000000;
      endcase
    end
  end

  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////
  cfg_reset_a: assert property (@(posedge clk)
    $past(rst) |-> cfg_q == IDC_CFG_RST)
    else $error("config not reset");

  clk_stop_a: assert property (@(posedge clk) disable iff (rst)
    sysclk_stop |-> cap_q[IDC_CLK_BIT] && cap_q[IDC_CLKE_BIT])
    else $error("clock stopped without both bits");

  clk_run_a: assert property (@(posedge clk) disable iff (rst)
    !cap_q[IDC_CLK_BIT] |-> !sysclk_stop)
    else $error("clock stopped with bit clear");

  mix_err_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_RUN && idle_exec && cfg_q[IDC_CLK_BIT] &&
    !cfg_q[IDC_CLKE_BIT] |=> ##1 bus_err_irq)
    else $error("mixed clock bits gave no error");

  dom_err_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_RUN && idle_exec && cfg_q[IDC_CLK_BIT] &&
    !cfg_q[IDC_MEMP_BIT] |=> state_q == IDC_ERR && !sysclk_stop)
    else $error("incomplete clock idle not refused");

  port_dis_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_RUN && idle_exec && !bad |=>
    dom_disable.memory_port == $past(cfg_q[IDC_MEMP_BIT]) &&
    dom_disable.io_port == $past(cfg_q[IDC_IOP_BIT]))
    else $error("port disable does not follow config");

  emi_dis_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_RUN && idle_exec && !bad |=>
    dom_disable.ext_mem_if == $past(cfg_q[IDC_EMI_BIT]) &&
    dom_disable.instr_port == $past(cfg_q[IDC_INSP_BIT]))
    else $error("interface disable does not follow config");

  low_dis_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_RUN && idle_exec && !bad |=>
    dom_disable.cpu == $past(cfg_q[IDC_CPU_BIT]) &&
    dom_disable.instr_cache == $past(cfg_q[IDC_ICACHE_BIT]))
    else $error("low domain disable does not follow config");

  hold_cap_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_IDLE && !wake |=> $stable(cap_q))
    else $error("captured config changed while idle");

  ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  clk_idle_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_RUN && idle_exec && !bad &&
    cfg_q[IDC_CLK_BIT] |=> sysclk_stop)
    else $error("valid clock idle did not stop the clock");

  err_no_dis_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_ERR |-> dom_disable == '0)
    else $error("domains disabled on a refused idle");

  err_hold_a: assert property (@(posedge clk) disable iff (rst)
    bus_err_irq && !(wr_stb && acc_adr == IDC_CMD_OFS) |=>
    bus_err_irq)
    else $error("bus error dropped without a clear");

  wake_clr_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IDC_IDLE && wake |=>
    dom_disable == '0 && !sysclk_stop)
    else $error("domains still disabled after wake");

  wake_c: cover property (@(posedge clk) disable iff (rst)
    state_q == IDC_IDLE && wake);
  no_idle_c: cover property (@(posedge clk) disable iff (rst)
    !sysclk_stop throughout (state_q == IDC_IDLE) [*2]);
  stop_c: cover property (@(posedge clk) disable iff (rst)
    sysclk_stop);
  err_c: cover property (@(posedge clk) disable iff (rst)
    $rose(bus_err_irq));

endmodule
`default_nettype wire

// ### test/idle_domain_control_tb.sv
// Self-checking bench of the idle domain control block
`timescale 1ns/1ps
`default_nettype none
module idle_domain_control_tb
  import idc_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  cyc = 1'b0;
  logic                  stb = 1'b0;
  logic                  we  = 1'b0;
  logic [IDC_ADDR_W-1:0] adr = '0;
  logic [31:0]           wdat = '0;
  logic [3:0]            sel = '0;
  logic [31:0]           rdat;
  logic                  ack;
  logic                  idle_exec = 1'b0;
  logic                  wake = 1'b0;
  idc_dom_t              dom_dis;
  logic                  stop;
  logic                  berr;
  int                    err_count = 0;
  int                    compares = 0;

  always #2.5 clk = ~clk;

  idle_domain_control i_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .idle_exec(idle_exec), .wake(wake),
    .dom_disable(dom_dis), .sysclk_stop(stop), .bus_err_irq(berr)
  );

  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until ack is sampled high at a rising edge
  task automatic wb_xfer(input logic w, input logic [3:0] a,
                         input logic [31:0] d, input logic [3:0] s,
                         output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    @(posedge clk);
    // Values read here are those the edge sampled
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) begin
      check("ack", 32'h0, 32'h1);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] r;
    wb_xfer(1'b1, a, d, s, r);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, a, 32'h0, 4'hF, r);
    check("read data", r, exp);
  endtask

  task automatic pulse(input logic is_idle);
    @(posedge clk);
    if (is_idle) idle_exec <= 1'b1;
    else wake <= 1'b1;
    @(posedge clk);
    idle_exec <= 1'b0;
    wake <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Config, IDLE, judge outputs, then clear any error and wake
  task automatic idle_chk(input logic [15:0] cfg, input logic [9:0] dis,
                          input logic stp, input logic err);
    wr(IDC_CFG_OFS, {16'h0, cfg}, 4'hF);
    pulse(1'b1);
    check("dom_disable", 32'(dom_dis), 32'(dis));
    check("sysclk_stop", 32'(stop), 32'(err ? 1'b0 : stp));
    check("bus_err_irq", 32'(berr), 32'(err));
    if (err) begin
      rd_chk(IDC_CMD_OFS, 32'h0000_0001);
      wr(IDC_CMD_OFS, 32'h1, 4'hF);
    end
    pulse(1'b0);
    check("woken", 32'({dom_dis, stop, berr}), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    check("reset outs", 32'({dom_dis, stop, berr}), 32'h0);
    rd_chk(IDC_CFG_OFS, 32'h0);
    wr(IDC_CFG_OFS, 32'hFFFF_FFFF, 4'hF);
    rd_chk(IDC_CFG_OFS, 32'h0000_03FF);
    wr(IDC_CFG_OFS, 32'h0, 4'h1);
    rd_chk(IDC_CFG_OFS, 32'h0000_0300);
    wr(4'hC, 32'hFFFF_FFFF, 4'hF);
    rd_chk(4'hC, 32'h0);
  endtask

  task automatic t_single_bits();
    for (int b = 0; b < 10; b++)
      if (b != IDC_CLK_BIT)
        idle_chk(16'h1 << b, 10'h1 << b, 1'b0, 1'b0);
    idle_chk(16'h0010, 10'h0, 1'b0, 1'b1);
  endtask

  task automatic t_clock_idle();
    idle_chk(16'h03F7, 10'h3F7, 1'b1, 1'b0);
    idle_chk(16'h03FF, 10'h3FF, 1'b1, 1'b0);
    idle_chk(16'h03EF, 10'h3EF, 1'b0, 1'b0);
  endtask

  task automatic t_bad_clock();
    for (int b = 0; b < 10; b++)
      if (IDC_CLK_REQ[b])
        idle_chk(16'h03F7 & ~(16'h1 << b), 10'h0, 1'b0, 1'b1);
  endtask

  // Later config writes must not touch domains already idled
  task automatic t_sample_hold();
    wr(IDC_CFG_OFS, 32'h0062, 4'hF);
    pulse(1'b1);
    wr(IDC_CFG_OFS, 32'h0180, 4'hF);
    check("held", 32'(dom_dis), 32'h0062);
    rd_chk(IDC_CFG_OFS, 32'h0000_0180);
    rd_chk(IDC_STAT_OFS, 32'h0000_0062);
    rd_chk(IDC_CMD_OFS, 32'h0000_0002);
    pulse(1'b0);
    idle_chk(16'h0180, 10'h180, 1'b0, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_regs();
    t_single_bits();
    t_clock_idle();
    t_bad_clock();
    t_sample_hold();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
